/* rtl/prs_pkg.sv */
// Package: constants and types for the power rail sequencer
package prs_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int MAX_RAILS = 32;
   localparam int NUM_RAILS = 4;
   localparam int CLK_HZ = 10000000;
   localparam int CLK_NS = 100;
   // ----------------------------------------------------------------
   // Timing, in ms as configured, and derived cycle counts
   // ----------------------------------------------------------------
   localparam int TURN_ON_DELAY_MS = 250;
   localparam int TURN_ON_TIMEOUT_MS = 25;
   localparam int TURN_ON_DELAY_CYC = TURN_ON_DELAY_MS * (CLK_HZ / 1000);
   localparam int TURN_ON_TIMEOUT_CYC =
      TURN_ON_TIMEOUT_MS * (CLK_HZ / 1000);
   // ----------------------------------------------------------------
   // Window band: tolerance in percent around nominal
   // ----------------------------------------------------------------
   localparam int BAND_PCT = 10;
   localparam int SENSE_W = 12;
   // ----------------------------------------------------------------
   // Prerequisite masks: each rail waits for all earlier rails
   // ----------------------------------------------------------------
   localparam logic [31:0] PREREQ_DEFAULT = 32'h00007310;
   // ----------------------------------------------------------------
   // AHB-Lite register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_FAULT = 8'h10;
   localparam logic [7:0] ADDR_NOM_BASE = 8'h20;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [SENSE_W-1:0] NOM_RESET = 12'h800;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // Event bits of the interrupt status register
   localparam int EV_FAULT = 0;
   localparam int EV_GOOD = 1;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RS_OFF, RS_DELAY, RS_WAIT_GOOD, RS_ON
   } prs_rail_state_type;
endpackage

/* rtl/prs_sync.sv */
// Two-flop synchroniser for a bus of level inputs
module prs_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] out;
   } prs_sync_type;
   prs_sync_type r, next_r;

   // First stage feeds only the second stage
   always_comb begin
      next_r.meta = d;
      next_r.out = r.meta;
   end

   // Register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.out;
endmodule

/* rtl/prs_window.sv */
// Window comparator: sensed level against a +/- band around nominal
module prs_window #(
   parameter int W = 12,
   parameter int PCT = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] sense,
   input wire logic [W-1:0] nominal,
   output logic good,
   output logic under,
   output logic over
);
   typedef struct packed {
      logic good;
      logic under;
      logic over;
   } prs_window_type;
   prs_window_type r, next_r;
   logic [W+7:0] band;
   logic [W+1:0] lo;
   logic [W+1:0] hi;

   // Band edges; widened so the upper edge cannot wrap
   always_comb begin
      band = (W+8)'((W+8)'(nominal) * (W+8)'(PCT) / (W+8)'(100));
      lo = (W+2)'(nominal) - (W+2)'(band);
      hi = (W+2)'(nominal) + (W+2)'(band);
      next_r.under = (W+2)'(sense) < lo;
      next_r.over = (W+2)'(sense) > hi;
      next_r.good = !next_r.under && !next_r.over;
   end

   // Register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign good = r.good;
   assign under = r.under;
   assign over = r.over;
endmodule

/* rtl/prs_top.sv */
// Power rail sequencer with fault shutdown, retry and AHB-Lite registers
// How it works
// (R1) Orders and times rail power-up; power-down drops all rails together; at most 32 rails.
// (R2) Each rail delivers a digital power-good input used for health.
// (R3) Optional per-rail window comparator yields power-good from sense level.
// (R4) Good inside +/-10 percent; under and over faults flagged outside.
// (R5) Separate under, over per rail kept for reporting.
// (R6) Any rail fault drops every rail enable.
// (R7) After fault shutdown the sequence restarts by itself.
// (R8) Power-good late after enable gives timeout fault, then retry.
// (R9) All-good output high only while every rail is powered.
// (R10) Default: four rails, one active-high control input, all-good and IRQ status outputs.
// (R11) One separate enable output per rail.
// (R12) A rail starts only after all rails in its prerequisite mask are up.
// (R13) After prerequisites, wait the turn-on delay before enabling.
// (R14) After enable, power-good within turn-on timeout or fault.
// (R15) Fault shutdown is immediate, retries never stop.
// (R16) Power-good inputs synchronised; fault status cleared when the first rail is enabled again.
module prs_top #(
   parameter int NUM_RAILS = prs_pkg::NUM_RAILS,
   parameter int TURN_ON_DELAY_CYC = prs_pkg::TURN_ON_DELAY_CYC,
   parameter int TURN_ON_TIMEOUT_CYC = prs_pkg::TURN_ON_TIMEOUT_CYC,
   parameter logic [31:0] PREREQ = prs_pkg::PREREQ_DEFAULT
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic SEQ_CONTROL,
   input wire logic [NUM_RAILS-1:0] POWER_GOOD,
   input wire logic [NUM_RAILS*prs_pkg::SENSE_W-1:0] RAIL_SENSE,
   output logic [NUM_RAILS-1:0] RAIL_ENABLE_OUT,
   output logic ALL_GOOD,
   output logic IRQ,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   localparam int SW = prs_pkg::SENSE_W;
   localparam int CW = 32;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      prs_pkg::prs_rail_state_type [NUM_RAILS-1:0] st;
      logic [NUM_RAILS-1:0][CW-1:0] cnt;
      logic [NUM_RAILS-1:0] en;
      logic [NUM_RAILS-1:0] uv;
      logic [NUM_RAILS-1:0] ov;
      logic [NUM_RAILS-1:0] tmo;
      logic [NUM_RAILS-1:0][SW-1:0] nom;
      logic [1:0] ctrl;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic all_good;
      logic irq;
      logic ph_act;
      logic ph_wr;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
   } prs_top_type;
   prs_top_type r, next_r;

   logic [NUM_RAILS-1:0] pg_sync;
   logic [NUM_RAILS-1:0] win_good;
   logic [NUM_RAILS-1:0] win_under;
   logic [NUM_RAILS-1:0] win_over;
   logic [NUM_RAILS-1:0] rail_good;
   logic [NUM_RAILS-1:0] powered;
   logic [NUM_RAILS-1:0] band_fault;
   logic any_fault;
   logic run;
   logic use_window;
   logic [31:0] mask_of;

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   // Regulator power-good arrives asynchronously
   prs_sync #(.W(NUM_RAILS)) u_pg_sync (
      .clk(CLK),
      .reset(RESET),
      .d(POWER_GOOD),
      .q(pg_sync)
   ); // R16

   // One window comparator per rail
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RAILS; gi++) begin : g_win
         prs_window #(.W(SW), .PCT(prs_pkg::BAND_PCT)) u_win (
            .clk(CLK),
            .reset(RESET),
            .sense(RAIL_SENSE[gi*SW +: SW]),
            .nominal(r.nom[gi]),
            .good(win_good[gi]),
            .under(win_under[gi]),
            .over(win_over[gi])
         ); // R3 R4
      end
   endgenerate

   // Select the source of power-good and find band faults
   always_comb begin
      use_window = r.ctrl[1];
      run = r.ctrl[0] && SEQ_CONTROL; // R10
      rail_good = use_window ? win_good : pg_sync; // R2 R3
      for (int i = 0; i < NUM_RAILS; i++) begin
         powered[i] = r.st[i] == prs_pkg::RS_ON;
         band_fault[i] = powered[i] &&
            (use_window ? (win_under[i] || win_over[i]) : !pg_sync[i]);
      end
      any_fault = |band_fault;
   end

   // ----------------------------------------------------------------
   // Sequencer, fault handling and register bus
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      mask_of = 32'h0;
      // Per-rail sequencing; a fault drops every rail the same cycle
      for (int i = 0; i < NUM_RAILS; i++) begin
         mask_of = (PREREQ >> (4 * i)) & 32'hf;
         case (r.st[i])
            prs_pkg::RS_OFF: begin
               next_r.en[i] = 1'b0;
               if (run && ((mask_of[NUM_RAILS-1:0] & ~powered) == '0)) begin
                  next_r.st[i] = prs_pkg::RS_DELAY; // R12
                  next_r.cnt[i] = '0;
               end
            end
            prs_pkg::RS_DELAY: begin
               next_r.cnt[i] = r.cnt[i] + 32'h1;
               if (r.cnt[i] >= CW'(TURN_ON_DELAY_CYC - 1)) begin
                  next_r.st[i] = prs_pkg::RS_WAIT_GOOD; // R13
                  next_r.en[i] = 1'b1; // R11
                  next_r.cnt[i] = '0;
               end
            end
            prs_pkg::RS_WAIT_GOOD: begin
               next_r.cnt[i] = r.cnt[i] + 32'h1;
               if (rail_good[i]) begin
                  next_r.st[i] = prs_pkg::RS_ON; // R14
               end else if (r.cnt[i] >= CW'(TURN_ON_TIMEOUT_CYC - 1)) begin
                  next_r.tmo[i] = 1'b1; // R8
               end
            end
            prs_pkg::RS_ON: begin
               next_r.en[i] = 1'b1;
            end
            default: begin
               next_r.st[i] = prs_pkg::RS_OFF;
            end
         endcase
         // Band faults latch separately per rail
         if (band_fault[i] && use_window) begin
            next_r.uv[i] = r.uv[i] | win_under[i]; // R5
            next_r.ov[i] = r.ov[i] | win_over[i]; // R5
         end else if (band_fault[i]) begin
            next_r.uv[i] = 1'b1;
         end
      end
      // Immediate group shutdown, then retry from OFF forever
      if (any_fault || (next_r.tmo & ~r.tmo) != '0 || !run) begin
         for (int i = 0; i < NUM_RAILS; i++) begin
            next_r.st[i] = prs_pkg::RS_OFF; // R6 R7 R15
            next_r.en[i] = 1'b0; // R6
         end
      end
      // Fault status clears when the first rail is enabled again; clearing
      // on leaving OFF would wipe it the cycle after shutdown, unread
      if (r.st[0] == prs_pkg::RS_DELAY &&
            next_r.st[0] == prs_pkg::RS_WAIT_GOOD) begin
         next_r.uv = '0; // R16
         next_r.ov = '0;
         next_r.tmo = '0;
      end
      next_r.all_good = (next_r.st == {NUM_RAILS{prs_pkg::RS_ON}}); // R9
      // Events: set wins over a software clear in the same cycle
      if (r.ph_act && r.ph_wr && r.ph_addr == prs_pkg::ADDR_IRQ_STAT) begin
         next_r.irq_stat = r.irq_stat & ~HWDATA[1:0];
      end
      if (any_fault || (next_r.tmo & ~r.tmo) != '0) begin
         next_r.irq_stat[prs_pkg::EV_FAULT] = 1'b1;
      end
      if (next_r.all_good && !r.all_good) begin
         next_r.irq_stat[prs_pkg::EV_GOOD] = 1'b1;
      end
      // Data phase write
      if (r.ph_act && r.ph_wr) begin
         case (r.ph_addr)
            prs_pkg::ADDR_CTRL: next_r.ctrl = HWDATA[1:0];
            prs_pkg::ADDR_IRQ_MASK: next_r.irq_mask = HWDATA[1:0];
            default: begin
               for (int i = 0; i < NUM_RAILS; i++) begin
                  if (r.ph_addr == 8'(prs_pkg::ADDR_NOM_BASE + 4 * i)) begin
                     next_r.nom[i] = HWDATA[SW-1:0];
                  end
               end
            end
         endcase
      end
      next_r.irq = (next_r.irq_stat & next_r.irq_mask) != 2'h0;
      // Address phase capture; zero-wait slave
      next_r.ph_act = HSEL && HREADY && HTRANS[1];
      next_r.ph_wr = HWRITE;
      next_r.ph_addr = HADDR[7:0];
      next_r.rdata = 32'h0;
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
         case (HADDR[7:0])
            prs_pkg::ADDR_CTRL: next_r.rdata = {30'h0, r.ctrl};
            prs_pkg::ADDR_STATUS: next_r.rdata =
               32'({r.all_good, r.en});
            prs_pkg::ADDR_IRQ_STAT: next_r.rdata = {30'h0, r.irq_stat};
            prs_pkg::ADDR_IRQ_MASK: next_r.rdata = {30'h0, r.irq_mask};
            prs_pkg::ADDR_FAULT: next_r.rdata =
               {8'h0, 8'(r.tmo), 8'(r.ov), 8'(r.uv)};
            default: begin
               for (int i = 0; i < NUM_RAILS; i++) begin
                  if (HADDR[7:0] == 8'(prs_pkg::ADDR_NOM_BASE + 4 * i)) begin
                     next_r.rdata = 32'(r.nom[i]);
                  end
               end
            end
         endcase
      end
   end

   // Register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         r <= '0;
         r.ctrl <= prs_pkg::CTRL_RESET;
         r.irq_mask <= prs_pkg::IRQ_MASK_RESET;
         for (int i = 0; i < NUM_RAILS; i++) begin
            r.nom[i] <= prs_pkg::NOM_RESET;
         end
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flops; bus always ready and OKAY
   assign RAIL_ENABLE_OUT = r.en; // R1 R11
   assign ALL_GOOD = r.all_good;
   assign IRQ = r.irq;
   assign HRDATA = r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
endmodule

/* tb/prs_chk_sva.sv */
// Port checker for the power rail sequencer
module prs_chk #(
   parameter int NUM_RAILS = prs_pkg::NUM_RAILS,
   parameter int TURN_ON_DELAY_CYC = prs_pkg::TURN_ON_DELAY_CYC,
   parameter int TURN_ON_TIMEOUT_CYC = prs_pkg::TURN_ON_TIMEOUT_CYC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic SEQ_CONTROL,
   input wire logic [NUM_RAILS-1:0] POWER_GOOD,
   input wire logic [NUM_RAILS-1:0] RAIL_ENABLE_OUT,
   input wire logic ALL_GOOD,
   input wire logic IRQ,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP
);
   localparam int LO_MAX = TURN_ON_DELAY_CYC + 8;
   localparam int WAIT_MAX = TURN_ON_TIMEOUT_CYC + 4;
   int lo_cnt;
   int wait_cnt;
   logic [3:0] en;
   assign en = RAIL_ENABLE_OUT[3:0];
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   // Rail one low time while run is asked; time a rail waits for good
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         lo_cnt <= 0;
         wait_cnt <= 0;
      end else begin
         lo_cnt <= (en[0] || !SEQ_CONTROL) ? 0 : lo_cnt + 1;
         wait_cnt <= |(en & ~POWER_GOOD) ? wait_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   bus_okay_a: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or gave an error");
   rdata_idle_a: assert property (
      !$past(HSEL && HTRANS[1] && HREADY && !HWRITE) |-> HRDATA == 32'h0)
      else $error("read data outside a read data phase");
   order_two_a: assert property (
      $rose(en[1]) |-> en[0] && POWER_GOOD[0])
      else $error("rail two enabled before rail one was up");
   order_four_a: assert property (
      $rose(en[3]) |-> &en[2:0] && &POWER_GOOD[2:0])
      else $error("rail four enabled before the others were up");
   drop_all_a: assert property (
      |($past(en) & ~en) |-> en == 4'h0)
      else $error("one enable fell while others stayed on");
   all_good_a: assert property (ALL_GOOD |-> &$past(en))
      else $error("all good while a rail was off");
   good_drop_a: assert property (en != 4'hf |=> !ALL_GOOD)
      else $error("all good held after a rail went off");
   on_delay_a: assert property (
      $rose(en[0]) |-> lo_cnt >= TURN_ON_DELAY_CYC)
      else $error("rail one enabled before its delay ran out");
   restart_a: assert property (lo_cnt <= LO_MAX)
      else $error("no restart after shutdown");
   timeout_a: assert property (wait_cnt <= WAIT_MAX)
      else $error("rail left enabled without good past its limit");
   cover property ($rose(ALL_GOOD));
   cover property ($fell(en[2]) && en[1:0] == 2'h0);
   cover property ($rose(IRQ));
endmodule

bind prs_top prs_chk #(.NUM_RAILS(NUM_RAILS),
   .TURN_ON_DELAY_CYC(TURN_ON_DELAY_CYC),
   .TURN_ON_TIMEOUT_CYC(TURN_ON_TIMEOUT_CYC)) u_chk (
   .CLK(CLK), .RESET(RESET), .SEQ_CONTROL(SEQ_CONTROL),
   .POWER_GOOD(POWER_GOOD), .RAIL_ENABLE_OUT(RAIL_ENABLE_OUT),
   .ALL_GOOD(ALL_GOOD), .IRQ(IRQ), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP));

/* tb/prs_reg_model.sv */
// Behavioural model of four regulators with enable inputs
module prs_reg_model (
   input wire logic clk,
   input wire logic [3:0] enable,
   input wire logic [3:0] hold_off,
   output logic [3:0] power_good,
   output logic [47:0] sense
);
   timeunit 1ns;
   timeprecision 1ns;
   int up_cnt [4];
   // Time since enable; later rails settle more slowly
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         up_cnt[i] <= enable[i] ? up_cnt[i] + 1 : 0;
      end
   end
   // Good is pulled low when off or held off, so no stale level shows
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         power_good[i] = enable[i] && !hold_off[i] && up_cnt[i] > i;
         sense[12*i +: 12] = power_good[i] ? 12'h800 : 12'h000;
      end
   end
endmodule

/* tb/power_rail_sequencer_bench.sv */
// Self-checking bench for the power rail sequencer
module power_rail_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DLY = 20;
   logic clk = 0;
   logic reset = 1;
   logic seq_ctl = 1;
   logic hsel = 0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] hold_off = 4'h0;
   logic [3:0] pgood, en;
   logic [47:0] sense;
   logic all_good, irq, hready, hresp;
   logic rd_phase = 0;
   logic [31:0] hrdata, rnd;
   logic [31:0] exp_q [$];
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0 = 0;
   int seed = 32'h0c40629f;
   wire [4:0] outs = {all_good, en};

   always #50 clk = ~clk;

   prs_top #(.TURN_ON_DELAY_CYC(DLY), .TURN_ON_TIMEOUT_CYC(10)) dut (
      .CLK(clk), .RESET(reset), .SEQ_CONTROL(seq_ctl),
      .POWER_GOOD(pgood), .RAIL_SENSE(sense), .RAIL_ENABLE_OUT(en),
      .ALL_GOOD(all_good), .IRQ(irq), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
   prs_reg_model model (.clk(clk), .enable(en), .hold_off(hold_off),
      .power_good(pgood), .sense(sense));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic give_verdict;
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Address phase held until ready, then data phase until ready
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(0, a, 32'h0);
   endtask
   // Bounded wait on one output bit: enables 0..3, all good 4
   task automatic wait_out(input int i, input logic v);
      for (int k = 0; k < 300 && outs[i] !== v; k++) @(posedge clk);
      check("output bit", {31'h0, outs[i]}, {31'h0, v});
   endtask

   // Read data compared in its data phase against the oldest note
   always @(posedge clk) begin
      if (rd_phase) check("read data", hrdata, exp_q.pop_front());
      rd_phase <= hsel && htrans[1] && !hwrite && hready;
   end
   // Cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      reset <= 0;
      check("reset outputs", {27'h0, irq, outs}, 32'h0);
      wait_out(0, 1);
      t0 = cyc;
      wait_out(1, 1);
      check("rail gap", 32'(cyc - t0 > DLY), 32'h1);
      wait_out(4, 1);
      rd(prs_pkg::ADDR_STATUS, 32'h1f);
      rd(prs_pkg::ADDR_CTRL, prs_pkg::CTRL_RESET);
      rd(prs_pkg::ADDR_IRQ_MASK, 32'h0);
      rd(prs_pkg::ADDR_IRQ_STAT, 32'h2);
      xfer(1, 8'h44, 32'hffffffff);
      rd(8'h44, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         rd(prs_pkg::ADDR_NOM_BASE + 8'(4 * i), 32'h800);
         xfer(1, prs_pkg::ADDR_NOM_BASE + 8'(4 * i), rnd);
         rd(prs_pkg::ADDR_NOM_BASE + 8'(4 * i), {20'h0, rnd[11:0]});
         xfer(1, prs_pkg::ADDR_NOM_BASE + 8'(4 * i), 32'h800);
      end
      check("masked irq", {31'h0, irq}, 32'h0);
      xfer(1, prs_pkg::ADDR_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h1);
      xfer(1, prs_pkg::ADDR_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      check("cleared irq", {31'h0, irq}, 32'h0);
      // Rail three loses good while on, then times out on retry until released
      hold_off <= 4'h4;
      wait_out(3, 0);
      check("enables", {28'h0, en}, 32'h0);
      check("all good", {31'h0, all_good}, 32'h0);
      rd(prs_pkg::ADDR_IRQ_STAT, 32'h1);
      rd(prs_pkg::ADDR_FAULT, 32'h4);
      check("fault irq", {31'h0, irq}, 32'h1);
      wait_out(0, 1);
      wait_out(2, 1);
      wait_out(2, 0);
      check("enables", {28'h0, en}, 32'h0);
      rd(prs_pkg::ADDR_FAULT, 32'h40000);
      wait_out(1, 1);
      hold_off <= 4'h0;
      wait_out(4, 1);
      // Control input low takes all rails down, high restarts
      seq_ctl <= 0;
      wait_out(0, 0);
      check("enables", {28'h0, en}, 32'h0);
      seq_ctl <= 1;
      wait_out(4, 1);
      // Window comparator as good source: over, then under faults
      xfer(1, prs_pkg::ADDR_CTRL, 32'h3);
      repeat (4) @(posedge clk);
      check("window good", {31'h0, all_good}, 32'h1);
      xfer(1, prs_pkg::ADDR_NOM_BASE + 8'h4, 32'h600);
      wait_out(1, 0);
      rd(prs_pkg::ADDR_FAULT, 32'h200);
      xfer(1, prs_pkg::ADDR_NOM_BASE + 8'h4, 32'h800);
      wait_out(4, 1);
      xfer(1, prs_pkg::ADDR_NOM_BASE + 8'hc, 32'ha00);
      wait_out(3, 0);
      rd(prs_pkg::ADDR_FAULT, 32'h8);
      xfer(1, prs_pkg::ADDR_NOM_BASE + 8'hc, 32'h800);
      wait_out(4, 1);
      give_verdict();
   end
endmodule
